// file: rtl/acd_pkg.sv
/*
 Constants, register map and codes of the converter calibration datapath.
 Assumes a 24-bit signed decimator result and a 32-bit AXI4-Lite register bus.
*/
// What this block does
// - Converter result is 24 bits, always handled as bipolar.
// - Offset and gain corrections are each 24-bit registers.
// - Reset loads offset with zero and gain with only the top bit set.
// - Result is raw minus offset, times gain, times amplifier gain.
// - Amplifier gain comes from the two-bit gain field of the control register.
// - Unipolar mode clamps negatives to zero and doubles the result.
// - Self offset calibration shorts inputs, converts, stores raw as offset.
// - Self gain calibration connects reference, stores reciprocal of raw minus offset.
// - Calibration outcomes land in the correction registers and are used afterwards.
// - System calibration needs zero input, then full-scale input, from outside.
// - Offset correction is signed two's complement, default zero.
// - Gain correction is unsigned, one integer bit and 23 fraction bits.
// - Data register changes only when a conversion completes with new corrections.
// - Gain selection or polarity changes show only after a new conversion.
// - Temperature sensor routed when positive select is 0111, negative 0000.
// - Unipolar results are straight binary, bipolar results two's complement.
// - Data spans 0..65535 unipolar, -32768..32767 bipolar.
package acd_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_GAIN = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam int CTRL_GAIN_LSB = 0;
    localparam int CTRL_UNI_BIT = 2;
    localparam int CTRL_POS_LSB = 4;
    localparam int CTRL_NEG_LSB = 8;
    localparam int CTRL_CAL_LSB = 12;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [23:0] GAIN_RESET = 24'h800000;
    localparam logic [23:0] GAIN_MAX = 24'hFFFFFF;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [3:0] TEMP_POS_SEL = 4'h7;
    localparam logic [3:0] TEMP_NEG_SEL = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] BASE_SHIFT = 5'h1F;
    localparam logic signed [49:0] UNI_MIN = 50'sh0;
    localparam logic signed [49:0] UNI_MAX = 50'sh0FFFF;
    localparam logic signed [49:0] BIP_MIN = -50'sh08000;
    localparam logic signed [49:0] BIP_MAX = 50'sh07FFF;
    localparam logic [46:0] RECIP_DIVIDEND = 47'h400000000000;
    localparam logic [5:0] RECIP_STEPS = 6'h2F;
    localparam logic [1:0] SETTLE_CONV = 2'h1;
    typedef enum logic [2:0] {
        CAL_NONE = 3'h0,
        CAL_SELF_OFFSET = 3'h1,
        CAL_SELF_GAIN = 3'h2,
        CAL_SYS_OFFSET = 3'h3,
        CAL_SYS_GAIN = 3'h4
    } acd_cal_type;
endpackage : acd_pkg

// file: rtl/acd_correct.sv
/*
 Two-stage correction pipeline: offset, gain, amplifier gain, polarity, clamp.
 Assumes settings are sampled with the conversion strobe.
*/
module acd_correct (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [23:0] raw_data,
    input wire logic [23:0] offset,
    input wire logic [23:0] gain,
    input wire logic [1:0] gain_sel,
    input wire logic unipolar,
    output logic out_valid,
    output logic [15:0] out_data
);
    logic signed [49:0] prod_ff, nxt_prod;
    logic [4:0] shift_ff, nxt_shift;
    logic uni_ff, nxt_uni, v1_ff, nxt_v1;
    logic [15:0] out_ff, nxt_out;
    logic v2_ff, nxt_v2;
    logic signed [24:0] diff;
    logic signed [49:0] scaled;

    function automatic logic [15:0] clamp(input logic signed [49:0] v, input logic signed [49:0] lo,
                                          input logic signed [49:0] hi);
        logic signed [49:0] r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return r[15:0];
    endfunction : clamp

    always_comb begin
        diff = $signed({raw_data[23], raw_data}) - $signed({offset[23], offset});
        nxt_prod = diff * $signed({1'b0, gain});
        nxt_shift = acd_pkg::BASE_SHIFT - {3'h0, gain_sel} - {4'h0, unipolar};
        nxt_uni = unipolar;
        nxt_v1 = in_valid;
        if (!in_valid) begin
            nxt_prod = prod_ff;
            nxt_shift = shift_ff;
            nxt_uni = uni_ff;
        end
        scaled = prod_ff >>> shift_ff;
        nxt_out = uni_ff ? clamp(scaled, acd_pkg::UNI_MIN, acd_pkg::UNI_MAX)
                         : clamp(scaled, acd_pkg::BIP_MIN, acd_pkg::BIP_MAX);
        nxt_v2 = v1_ff;
        if (!v1_ff) begin
            nxt_out = out_ff;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prod_ff <= '0;
            shift_ff <= acd_pkg::BASE_SHIFT;
            uni_ff <= 1'b0;
            v1_ff <= 1'b0;
            out_ff <= acd_pkg::DATA_RESET;
            v2_ff <= 1'b0;
        end else begin
            prod_ff <= nxt_prod;
            shift_ff <= nxt_shift;
            uni_ff <= nxt_uni;
            v1_ff <= nxt_v1;
            out_ff <= nxt_out;
            v2_ff <= nxt_v2;
        end
    end

    assign out_valid = v2_ff;
    assign out_data = out_ff;
endmodule : acd_correct

// file: rtl/acd_recip.sv
/*
 Serial restoring divider giving 2^46 / divisor, saturated to 24 bits.
 Assumes the divisor is positive and held only at the start pulse.
*/
module acd_recip (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [24:0] divisor,
    output logic done,
    output logic [23:0] quotient
);
    logic busy_ff, nxt_busy, done_ff, nxt_done;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [25:0] rem_ff, nxt_rem, rem_sh;
    logic [46:0] quo_ff, nxt_quo;
    logic [24:0] div_ff, nxt_div;
    logic [23:0] q_ff, nxt_q;

    always_comb begin
        nxt_busy = busy_ff;
        nxt_cnt = cnt_ff;
        nxt_rem = rem_ff;
        nxt_quo = quo_ff;
        nxt_div = div_ff;
        nxt_q = q_ff;
        nxt_done = 1'b0;
        rem_sh = {rem_ff[24:0], quo_ff[46]};
        if (start) begin
            nxt_busy = 1'b1;
            nxt_cnt = acd_pkg::RECIP_STEPS;
            nxt_rem = '0;
            nxt_quo = acd_pkg::RECIP_DIVIDEND;
            nxt_div = divisor;
        end else if (busy_ff) begin
            nxt_quo = {quo_ff[45:0], 1'b0};
            nxt_rem = rem_sh;
            if (rem_sh >= {1'b0, div_ff}) begin
                nxt_rem = rem_sh - {1'b0, div_ff};
                nxt_quo[0] = 1'b1;
            end
            nxt_cnt = cnt_ff - 6'h01;
            if (cnt_ff == 6'h01) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                // Gain above just-under-two cannot be held
                nxt_q = (nxt_quo[46:24] != '0) ? acd_pkg::GAIN_MAX : nxt_quo[23:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff <= '0;
            rem_ff <= '0;
            quo_ff <= '0;
            div_ff <= '0;
            q_ff <= acd_pkg::GAIN_RESET;
        end else begin
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            cnt_ff <= nxt_cnt;
            rem_ff <= nxt_rem;
            quo_ff <= nxt_quo;
            div_ff <= nxt_div;
            q_ff <= nxt_q;
        end
    end

    assign done = done_ff;
    assign quotient = q_ff;
endmodule : acd_recip

// file: rtl/acd_calib_top.sv
/*
 Top of the converter calibration datapath: AXI4-Lite registers,
 calibration sequencer, input routing and the data register.
 Assumes raw_valid is a one-cycle strobe per finished decimator result.
*/
module acd_calib_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [acd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [acd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic raw_valid,
    input wire logic [23:0] raw_data,
    output logic [3:0] positive_input_select,
    output logic [3:0] negative_input_select,
    output logic [1:0] input_amplifier_multiplier,
    output logic temp_sensor_route,
    output logic input_short,
    output logic reference_connect
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_CONV = 4'b0100,
        ST_DIV = 4'b1000
    } acd_state_type;

    // Bus state
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [11:0] ctrl_ff, nxt_ctrl;
    logic temp_ff, nxt_temp;
    logic aw_take, w_take, ar_take, bus_wr;
    logic wr_ctrl, wr_off, wr_gain, cal_req;
    logic [7:0] wa, ra;
    acd_pkg::acd_cal_type req_mode;

    // Calibration state
    acd_state_type state_ff, nxt_state;
    acd_pkg::acd_cal_type mode_ff, nxt_mode;
    logic [1:0] settle_ff, nxt_settle;
    logic [23:0] offset_ff, nxt_offset, gain_ff, nxt_gain;
    logic [15:0] data_ff, nxt_data;
    logic short_ff, nxt_short, ref_ff, nxt_ref;
    logic div_start;
    logic signed [24:0] cal_diff;
    logic is_offset_mode;

    logic corr_valid, div_done;
    logic [15:0] corr_data;
    logic [23:0] div_q;

    function automatic logic [7:0] word_addr(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_addr

    function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        logic [23:0] r;
        r = old;
        for (int i = 0; i < 3; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge24

    always_comb begin
        aw_take = s_axi_awvalid & awready_ff;
        w_take = s_axi_wvalid & wready_ff;
        ar_take = s_axi_arvalid & arready_ff;
        nxt_aw_full = aw_full_ff | aw_take;
        nxt_w_full = w_full_ff | w_take;
        nxt_awaddr = aw_take ? s_axi_awaddr : awaddr_ff;
        nxt_wdata = w_take ? s_axi_wdata : wdata_ff;
        nxt_wstrb = w_take ? s_axi_wstrb : wstrb_ff;
        nxt_bvalid = bvalid_ff & ~s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        bus_wr = nxt_aw_full & nxt_w_full & ~bvalid_ff;
        wa = word_addr(nxt_awaddr);
        wr_ctrl = bus_wr && (wa == acd_pkg::ADDR_CTRL);
        wr_off = bus_wr && (wa == acd_pkg::ADDR_OFFSET);
        wr_gain = bus_wr && (wa == acd_pkg::ADDR_GAIN);
        req_mode = acd_pkg::acd_cal_type'(nxt_wdata[acd_pkg::CTRL_CAL_LSB +: 3]);
        cal_req = wr_ctrl && nxt_wstrb[1] && (req_mode != acd_pkg::CAL_NONE);
        if (bus_wr) begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = acd_pkg::RESP_OKAY;
            if (!(wr_ctrl || wr_off || wr_gain || wa == acd_pkg::ADDR_STATUS
                  || wa == acd_pkg::ADDR_DATA)) begin
                nxt_bresp = acd_pkg::RESP_SLVERR;
            end
        end
        if (wr_ctrl) begin
            if (nxt_wstrb[0]) begin
                nxt_ctrl[7:0] = nxt_wdata[7:0];
                nxt_ctrl[3] = 1'b0;
            end
            if (nxt_wstrb[1]) begin
                nxt_ctrl[11:8] = nxt_wdata[11:8];
            end
        end
        nxt_temp = (nxt_ctrl[acd_pkg::CTRL_POS_LSB +: 4] == acd_pkg::TEMP_POS_SEL)
                   && (nxt_ctrl[acd_pkg::CTRL_NEG_LSB +: 4] == acd_pkg::TEMP_NEG_SEL);
        nxt_awready = ~nxt_aw_full & ~nxt_bvalid;
        nxt_wready = ~nxt_w_full & ~nxt_bvalid;
        nxt_rvalid = rvalid_ff & ~s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        ra = word_addr(s_axi_araddr);
        if (ar_take) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = acd_pkg::RESP_OKAY;
            case (ra)
                acd_pkg::ADDR_CTRL: begin
                    nxt_rdata = {17'h0, mode_ff, ctrl_ff};
                end
                acd_pkg::ADDR_STATUS: begin
                    nxt_rdata = {31'h0, state_ff != ST_IDLE};
                end
                acd_pkg::ADDR_OFFSET: begin
                    nxt_rdata = {8'h00, offset_ff};
                end
                acd_pkg::ADDR_GAIN: begin
                    nxt_rdata = {8'h00, gain_ff};
                end
                acd_pkg::ADDR_DATA: begin
                    nxt_rdata = {16'h0000, data_ff};
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = acd_pkg::RESP_SLVERR;
                end
            endcase
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= acd_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= acd_pkg::RESP_OKAY;
            ctrl_ff <= acd_pkg::CTRL_RESET;
            temp_ff <= 1'b0;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            temp_ff <= nxt_temp;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_settle = settle_ff;
        nxt_offset = offset_ff;
        nxt_gain = gain_ff;
        nxt_data = data_ff;
        div_start = 1'b0;
        cal_diff = $signed({raw_data[23], raw_data}) - $signed({offset_ff[23], offset_ff});
        is_offset_mode = (mode_ff == acd_pkg::CAL_SELF_OFFSET) || (mode_ff == acd_pkg::CAL_SYS_OFFSET);
        if (wr_off) begin
            nxt_offset = merge24(offset_ff, nxt_wdata, nxt_wstrb);
        end
        if (wr_gain) begin
            nxt_gain = merge24(gain_ff, nxt_wdata, nxt_wstrb);
        end
        if (corr_valid) begin
            nxt_data = corr_data;
        end
        case (state_ff)
            ST_IDLE: begin
                if (cal_req) begin
                    nxt_mode = req_mode;
                    nxt_settle = acd_pkg::SETTLE_CONV;
                    nxt_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Drops the conversion already running when inputs switched
                if (raw_valid) begin
                    nxt_settle = settle_ff - 2'h1;
                    if (settle_ff == 2'h1) begin
                        nxt_state = ST_CONV;
                    end
                end
            end
            ST_CONV: begin
                if (raw_valid) begin
                    nxt_state = ST_IDLE;
                    nxt_mode = acd_pkg::CAL_NONE;
                    if (is_offset_mode) begin
                        nxt_offset = raw_data;
                    end else if (cal_diff <= 25'sh0) begin
                        nxt_gain = acd_pkg::GAIN_MAX;
                    end else begin
                        div_start = 1'b1;
                        nxt_mode = mode_ff;
                        nxt_state = ST_DIV;
                    end
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    nxt_gain = div_q;
                    nxt_mode = acd_pkg::CAL_NONE;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_mode = acd_pkg::CAL_NONE;
            end
        endcase
        nxt_short = (nxt_state == ST_SETTLE || nxt_state == ST_CONV)
                    && (nxt_mode == acd_pkg::CAL_SELF_OFFSET);
        nxt_ref = (nxt_state == ST_SETTLE || nxt_state == ST_CONV)
                  && (nxt_mode == acd_pkg::CAL_SELF_GAIN);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            mode_ff <= acd_pkg::CAL_NONE;
            settle_ff <= 2'h0;
            offset_ff <= acd_pkg::OFFSET_RESET;
            gain_ff <= acd_pkg::GAIN_RESET;
            data_ff <= acd_pkg::DATA_RESET;
            short_ff <= 1'b0;
            ref_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            settle_ff <= nxt_settle;
            offset_ff <= nxt_offset;
            gain_ff <= nxt_gain;
            data_ff <= nxt_data;
            short_ff <= nxt_short;
            ref_ff <= nxt_ref;
        end
    end

    acd_correct u_correct (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_valid(raw_valid && (state_ff == ST_IDLE)),
        .raw_data(raw_data),
        .offset(offset_ff),
        .gain(gain_ff),
        .gain_sel(ctrl_ff[acd_pkg::CTRL_GAIN_LSB +: 2]),
        .unipolar(ctrl_ff[acd_pkg::CTRL_UNI_BIT]),
        .out_valid(corr_valid),
        .out_data(corr_data)
    );

    acd_recip u_recip (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(div_start),
        .divisor(cal_diff[24:0]),
        .done(div_done),
        .quotient(div_q)
    );

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign positive_input_select = ctrl_ff[acd_pkg::CTRL_POS_LSB +: 4];
    assign negative_input_select = ctrl_ff[acd_pkg::CTRL_NEG_LSB +: 4];
    assign input_amplifier_multiplier = ctrl_ff[acd_pkg::CTRL_GAIN_LSB +: 2];
    assign temp_sensor_route = temp_ff;
    assign input_short = short_ff;
    assign reference_connect = ref_ff;
endmodule : acd_calib_top

// file: bench/acd_calib_properties.sv
/* Port-level checker for acd_calib_top.
   Assumes binding to every instance of the top. */
module acd_calib_properties (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] positive_input_select,
    input wire logic [3:0] negative_input_select,
    input wire logic temp_sensor_route,
    input wire logic input_short,
    input wire logic reference_connect
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not released");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not released");
    temp_route_a: assert property (temp_sensor_route ==
        (positive_input_select == 4'h7 && negative_input_select == 4'h0))
        else $error("temperature route wrong");
    cal_excl_a: assert property (!(input_short && reference_connect))
        else $error("short and reference together");
    ref_span_a: assert property ($rose(reference_connect) |=> reference_connect)
        else $error("reference pulse too short");
endmodule : acd_calib_properties

bind acd_calib_top acd_calib_properties u_chk (.*);

// file: bench/tb.sv
/* Self-checking bench for acd_calib_top.
   Drives AXI4-Lite and decimator strobes directly. */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, resetn = 1'b0, raw_valid = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [23:0] raw_data = 24'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, input_amplifier_multiplier;
    logic [3:0] positive_input_select, negative_input_select;
    logic temp_sensor_route, input_short, reference_connect;
    int errors = 0, cmp_count = 0, cyc = 0;
    // Raw word, {unipolar, gain select}, expected data
    localparam logic [42:0] ROWS [11] = '{
        {24'h001000, 3'h0, 16'h0010}, {24'h001000, 3'h3, 16'h0080},
        {24'h001000, 3'h2, 16'h0040}, {24'hFFF000, 3'h0, 16'hFFF0},
        {24'hFFF000, 3'h4, 16'h0000}, {24'h001000, 3'h5, 16'h0040},
        {24'hFFFFFF, 3'h0, 16'hFFFF}, {24'h7FFFFF, 3'h0, 16'h7FFF},
        {24'h800000, 3'h3, 16'h8000}, {24'h7FFFFF, 3'h3, 16'h7FFF},
        {24'h7FFFFF, 3'h4, 16'hFFFF}};

    acd_calib_top uut (.*);

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, resp});
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, resp});
    endtask : rd_chk

    task automatic conv(input logic [23:0] r);
        raw_data <= r;
        raw_valid <= 1'b1;
        @(posedge core_clk);
        raw_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : conv

    task automatic complete_run();
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            complete_run();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd_chk(8'h08, 32'h0, 2'h0);
        rd_chk(8'h0C, 32'h800000, 2'h0);
        rd_chk(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h1, 2'h2);
        for (int i = 0; i < 11; i++) begin
            wr(8'h00, {29'h0, ROWS[i][18:16]});
            conv(ROWS[i][42:19]);
            chk({30'h0, input_amplifier_multiplier}, {30'h0, ROWS[i][17:16]});
            rd_chk(8'h10, {16'h0, ROWS[i][15:0]}, 2'h0);
        end
        wr(8'h00, 32'h0);
        wr(8'h08, 32'hFFF000);
        rd_chk(8'h10, 32'hFFFF, 2'h0);
        conv(24'h001000);
        rd_chk(8'h10, 32'h0020, 2'h0);
        wr(8'h0C, 32'h400000);
        conv(24'h001000);
        rd_chk(8'h10, 32'h0010, 2'h0);
        wr(8'h00, 32'h1000);
        chk({31'h0, input_short}, 32'h1);
        conv(24'h000000);
        conv(24'h000100);
        chk({31'h0, input_short}, 32'h0);
        rd_chk(8'h08, 32'h000100, 2'h0);
        wr(8'h00, 32'h2000);
        chk({31'h0, reference_connect}, 32'h1);
        conv(24'h000000);
        conv(24'h500100);
        rd_chk(8'h04, 32'h1, 2'h0);
        repeat (50) @(posedge core_clk);
        rd_chk(8'h0C, 32'hCCCCCC, 2'h0);
        conv(24'h500100);
        rd_chk(8'h10, 32'h7FFF, 2'h0);
        wr(8'h00, 32'h0070);
        chk({31'h0, temp_sensor_route}, 32'h1);
        chk({28'h0, positive_input_select}, 32'h7);
        wr(8'h00, 32'h0170);
        chk({31'h0, temp_sensor_route}, 32'h0);
        chk({28'h0, negative_input_select}, 32'h1);
        wr(8'h00, 32'h3000);
        chk({31'h0, input_short}, 32'h0);
        conv(24'h000000);
        conv(24'h000200);
        rd_chk(8'h08, 32'h000200, 2'h0);
        wr(8'h00, 32'h4000);
        chk({31'h0, reference_connect}, 32'h0);
        conv(24'h000000);
        conv(24'h000100);
        rd_chk(8'h0C, 32'hFFFFFF, 2'h0);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd_chk(8'h08, 32'h0, 2'h0);
        rd_chk(8'h0C, 32'h800000, 2'h0);
        rd_chk(8'h10, 32'h0, 2'h0);
        complete_run();
    end
endmodule : tb
